// ### sim/host_port_model.sv
module host_port_model (
	input wire logic sys_clk,
	output logic reg_wr, reg_rd, soft_reset_n,
	output logic [7:0] reg_addr, reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_wr, reg_rd, soft_reset_n, reg_addr, reg_wdata} = 19'h10000;
	// Released lines show the inverse so a stale byte never looks valid.
	task automatic access(input logic w, input logic [7:0] a, d);
		@(posedge sys_clk) #1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge sys_clk) #1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
	endtask
	task automatic soft_reset();
		@(posedge sys_clk) #1 soft_reset_n = 0;
		repeat (6) @(posedge sys_clk);
		#1 soft_reset_n = 1;
	endtask
endmodule

// ### sim/mode_control_checker.sv
module mode_control_checker #(parameter CHANNELS = 14) (
	input wire logic sys_clk, sys_rst, reg_wr, host_access_ok, soft_reset_n, tx_oe_n,
	input wire logic core_active, internal_clear, buffered_clock_output, link_fault,
	input wire logic [7:0] reg_addr, reg_wdata, buf_area_last,
	input wire logic [6:0] own_pointer, buf_start,
	input wire logic [4:0] own_length, buf_length,
	input wire logic [7*CHANNELS-1:0] all_pointer,
	input wire logic [5*CHANNELS-1:0] all_length
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic cmd = reg_wr && host_access_ok && reg_addr == 8'h03;
	wire logic [4:0] tlen = all_length[own_pointer*5 +: 5];
	a_start_idle: assert property ($fell(sys_rst) |-> !core_active) else $error("busy");
	a_idle_released: assert property (!core_active |-> tx_oe_n) else $error("driven");
	a_go_active: assert property (cmd && reg_wdata[2:0] == 3'h1 |-> ##2 core_active)
		else $error("no start");
	a_stay_idle: assert property (cmd && reg_wdata[2:0] == 3'h3 && !core_active |-> ##2 !core_active)
		else $error("woke");
	a_sleep_wins: assert property (cmd && reg_wdata[2] |-> ##2 internal_clear) else $error("awake");
	a_sleep_quiet: assert property (internal_clear && $past(internal_clear)
		|-> !host_access_ok && !buffered_clock_output) else $error("noisy");
	a_sleep_holds: assert property (internal_clear && soft_reset_n |=> internal_clear)
		else $error("left");
	a_own_buffer: assert property (own_length != 0 |-> buf_start == own_pointer
		&& buf_length == own_length && !link_fault) else $error("own");
	a_link_target: assert property (own_length == 0 && own_pointer < CHANNELS
		|-> buf_start == all_pointer[own_pointer*7 +: 7] && buf_length == tlen
		&& link_fault == (tlen == 0)) else $error("link");
	a_area_size: assert property (buf_area_last == 8'h7f) else $error("area");
endmodule
bind mode_control mode_control_checker #(.CHANNELS(CHANNELS)) u_chk (.*);

// ### sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, sys_rst, tx_pending, tx_data, reg_wr, reg_rd, soft_reset_n, tx_out;
	logic host_access_ok, tx_oe_n, core_active, internal_clear, buffered_clock_output;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, buf_area_last;
	logic [6:0] own_pointer, buf_start;
	logic [4:0] own_length, buf_length;
	logic [97:0] all_pointer;
	logic [69:0] all_length;
	logic link_fault;
	int failures = 0, tests_run = 0, cycles = 0;
	host_port_model u_host (.sys_clk, .reg_wr, .reg_rd, .soft_reset_n, .reg_addr, .reg_wdata);
	mode_control u_dut (.*);
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			failures++;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_idle();
		logic clk_seen;
		u_host.access(0, 8'h04, 8'h00);
		chk(reg_rdata, 8'h01);
		clk_seen = buffered_clock_output;
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h00, clk_seen ^ buffered_clock_output}, 8'h01);
		chk({7'h00, tx_out}, 8'h01);
		chk(buf_area_last, 8'h7f);
		u_host.access(1, 8'h03, 8'h03);
		settle();
		chk({core_active, tx_oe_n}, 8'h01);
		$display("idle done");
	endtask
	task automatic t_active();
		tx_data = 0;
		tx_pending = 1;
		u_host.access(1, 8'h03, 8'h01);
		settle();
		chk({core_active, tx_oe_n, tx_out}, 8'h04);
		u_host.access(0, 8'h04, 8'h00);
		chk(reg_rdata, 8'h02);
		u_host.access(1, 8'h03, 8'h02);
		settle();
		chk(core_active, 8'h01);
		tx_pending = 0;
		settle();
		chk({core_active, tx_oe_n}, 8'h01);
		$display("active done");
	endtask
	task automatic t_link();
		@(posedge sys_clk) #1;
		all_length[25+:5] = 5'h09;
		all_pointer[35+:7] = 7'h14;
		{own_length, own_pointer} = 12'h005;
		#1 chk({1'b0, buf_start}, 8'h14);
		chk(buf_length, 8'h09);
		chk(link_fault, 8'h00);
		own_pointer = 7'h06;
		#1 chk(link_fault, 8'h01);
		{own_length, own_pointer} = 12'h1a2;
		#1 chk({buf_start, link_fault}, 8'h44);
		$display("link done");
	endtask
	task automatic t_sleep();
		u_host.access(1, 8'h03, 8'h07);
		settle();
		settle();
		chk({internal_clear, host_access_ok, buffered_clock_output}, 8'h04);
		u_host.access(1, 8'h03, 8'h01);
		settle();
		chk({internal_clear, core_active}, 8'h02);
		u_host.soft_reset();
		settle();
		chk({internal_clear, core_active}, 8'h00);
		$display("sleep done");
	endtask
	initial
	begin
		sys_clk = 0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (++cycles == 3000)
		begin
			failures++;
			give_verdict();
		end
	initial
	begin
		{sys_rst, tx_pending, tx_data, own_pointer, own_length} = 15'h5001;
		{all_pointer, all_length} = '0;
		repeat (5) @(posedge sys_clk);
		#1 sys_rst = 0;
		t_idle();
		t_active();
		t_link();
		t_sleep();
		give_verdict();
	end
endmodule

// ### src/link_resolver.v
`include "mode_link_map.vh"

module link_resolver
#(
	parameter CHANNELS = 14
)
(
	// Selected channel and its own buffer fields.
	input  wire [6:0]            own_pointer,
	input  wire [4:0]            own_length,
	// Pointer and length of every channel, flattened.
	input  wire [7*CHANNELS-1:0] all_pointer,
	input  wire [5*CHANNELS-1:0] all_length,
	// Resolved shared buffer.
	output reg  [6:0]            buf_start,
	output reg  [4:0]            buf_length,
	output reg                   link_fault
);

	integer i;

	always @*
	begin
		buf_start  = own_pointer;
		buf_length = own_length;
		link_fault = 1'b0;
		if (own_length == 5'h00)
		begin
			// The pointer names the target channel.
			buf_start  = 7'h00;
			buf_length = 5'h00;
			link_fault = 1'b1;
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				if (own_pointer == i[6:0])
				begin
					buf_start  = all_pointer[7*i +: 7];
					buf_length = all_length[5*i +: 5];
					// Target that is itself linked is rejected.
					link_fault = (all_length[5*i +: 5] == 5'h00);
				end
			end
		end
	end

endmodule

// ### src/mode_control.v
`include "mode_link_map.vh"

// Functional notes
// - Every reset lands in idle mode.
// - Transmit pin released while idle.
// - Activate set, idle clear makes active.
// - Line status reports idle state.
// - Sleep bit wins over other bits.
// - Sleep clears internals, stops clock.
// - Sleep blocks host access and clock out.
// - Only reset pin or soft reset wake.
// - Zero length marks channel linked.
// - Linked pointer gives target channel number.
// - Linked channel uses target's start, length.
// - Single linkage level only.
// - Other channel settings stay independent.
// - Buffers share one 128-byte area.
// - Idle waits for pending transmits.
module mode_control
#(
	parameter CHANNELS = 14,
	parameter CLK_DIV  = 2
)
(
	// Clock and synchronous reset.
	input  wire                  sys_clk,
	input  wire                  sys_rst,
	// Host register port, already decoded from the serial link.
	input  wire                  reg_wr,
	input  wire                  reg_rd,
	input  wire [7:0]            reg_addr,
	input  wire [7:0]            reg_wdata,
	output reg  [7:0]            reg_rdata,
	output wire                  host_access_ok,
	// Asynchronous software reset request from the serial port.
	input  wire                  soft_reset_n,
	// Transmit engine status and data.
	input  wire                  tx_pending,
	input  wire                  tx_data,
	output wire                  tx_out,
	output wire                  tx_oe_n,
	output wire                  core_active,
	output wire                  internal_clear,
	// Buffered clock output.
	output reg                   buffered_clock_output,
	// Channel linkage lookup.
	input  wire [6:0]            own_pointer,
	input  wire [4:0]            own_length,
	input  wire [7*CHANNELS-1:0] all_pointer,
	input  wire [5*CHANNELS-1:0] all_length,
	output wire [6:0]            buf_start,
	output wire [4:0]            buf_length,
	output wire                  link_fault,
	output wire [7:0]            buf_area_last
);

	localparam ST_IDLE   = 2'd0;
	localparam ST_ACTIVE = 2'd1;
	localparam ST_SLEEP  = 2'd2;

	reg  [1:0] state;
	reg  [1:0] next_state;
	reg  [7:0] mode_command;
	reg        soft_meta;
	reg        soft_sync;
	reg  [7:0] div_count;
	reg  [7:0] next_mode_command;
	reg  [7:0] next_div_count;
	reg        next_clock;
	reg  [7:0] next_rdata;
	wire [7:0] line_status;
	wire [31:0] area_last_full;

	wire sleeping   = (state == ST_SLEEP);
	// Sleep has no exit of its own: only the reset pin or the soft reset wakes it.
	wire wake_reset = sys_rst | ~soft_sync;

	assign host_access_ok = ~sleeping;
	assign core_active    = (state == ST_ACTIVE);
	assign tx_oe_n        = ~core_active;

	// The data line idles recessive so a pull-up and this output never fight.
	assign tx_out         = core_active ? tx_data : 1'b1;
	assign internal_clear = sleeping;

	// Every channel's buffer sits in one shared data area.
	assign area_last_full = `MSG_AREA_BYTES - 1;
	assign buf_area_last  = area_last_full[7:0];

	// Line status is built bit by bit so the field positions stay in one place.
	assign line_status[`LINE_IDLE_BIT]   = (state == ST_IDLE);
	assign line_status[`LINE_ACTIVE_BIT] = core_active;
	assign line_status[7:2]              = 6'h00;

	// Soft reset comes from another domain, so it is synchronised first.
	always @(posedge sys_clk)
	begin
		soft_meta <= soft_reset_n;
		soft_sync <= soft_meta;
	end

	// Writes are dropped in sleep, so a stale command cannot wake the core.
	always @*
	begin
		next_mode_command = mode_command;
		if (reg_wr && !sleeping && reg_addr == `ADDR_MODE_COMMAND)
			next_mode_command = reg_wdata;
	end

	always @(posedge sys_clk)
	begin
		if (wake_reset)
			mode_command <= `MODE_COMMAND_RESET;
		else
			mode_command <= next_mode_command;
	end

	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE, ST_ACTIVE:
			begin
				if (mode_command[`CMD_SLEEP_BIT])
					next_state = ST_SLEEP;
				else if (mode_command[`CMD_ACTIVATE_BIT] && !mode_command[`CMD_IDLE_BIT])
					next_state = ST_ACTIVE;
				else if (!tx_pending)
					// Idle is deferred while attempts remain, so no frame is cut short.
					next_state = ST_IDLE;
			end
			ST_SLEEP:
				next_state = ST_SLEEP;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk)
	begin
		if (wake_reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always @*
	begin
		next_div_count = div_count + 8'h01;
		next_clock     = buffered_clock_output;
		if (div_count == CLK_DIV - 1)
		begin
			next_div_count = 8'h00;
			next_clock     = ~buffered_clock_output;
		end
	end

	// The clock output models the stopped oscillator: it freezes low in sleep.
	// A host clocked from this pin stops with it, so only a reset revives it.
	always @(posedge sys_clk)
	begin
		if (wake_reset || sleeping)
		begin
			div_count             <= 8'h00;
			buffered_clock_output <= 1'b0;
		end
		else
		begin
			div_count             <= next_div_count;
			buffered_clock_output <= next_clock;
		end
	end

	// Read data holds until the next read, so the host may fetch it late.
	always @*
	begin
		next_rdata = reg_rdata;
		if (reg_rd && !sleeping)
		begin
			case (reg_addr)
				`ADDR_MODE_COMMAND:
					next_rdata = mode_command;
				`ADDR_BUS_LINE_STATE:
					next_rdata = line_status;
				default:
					next_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	// Only buffer start and length are resolved; other settings stay per channel.
	link_resolver
	#(
		.CHANNELS    (CHANNELS)
	)
	u_link
	(
		.own_pointer (own_pointer),
		.own_length  (own_length),
		.all_pointer (all_pointer),
		.all_length  (all_length),
		.buf_start   (buf_start),
		.buf_length  (buf_length),
		.link_fault  (link_fault)
	);

endmodule

// ### src/mode_link_map.vh
`ifndef MODE_LINK_MAP_VH
`define MODE_LINK_MAP_VH

// Register addresses on the host port.
`define ADDR_MODE_COMMAND     8'h03
`define ADDR_BUS_LINE_STATE   8'h04

// Field positions in mode_command.
`define CMD_SLEEP_BIT         2
`define CMD_IDLE_BIT          1
`define CMD_ACTIVATE_BIT      0

// Field positions in bus_line_state.
`define LINE_IDLE_BIT         0
`define LINE_ACTIVE_BIT       1

// Reset values.
`define MODE_COMMAND_RESET    8'h00

// Channel register offsets within a channel's register set.
`define CHAN_PTR_OFFSET       8'h02
`define CHAN_LEN_OFFSET       8'h03

// Message data area size in bytes.
`define MSG_AREA_BYTES        128

`endif
